// file: exc_unit.sv
// Exception decision unit: deferred fp error, alignment fault, machine abort
//
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module exc_unit
    import exc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core state
    input wire logic [1:0] current_privilege_level,
    input wire logic [31:0] instr_ptr,
    // Fp unit side
    input wire logic fp_error_detect,
    input wire logic [5:0] fp_error_type,
    input wire logic ins_valid,
    input wire logic [1:0] ins_class,
    // Data access check
    input wire logic acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic [3:0] acc_kind,
    input wire logic acc_opsize32,
    input wire logic acc_data_seg,
    input wire logic acc_implicit_pl0,
    output logic acc_go,
    // External error pins
    input wire logic check_error_pin_n,
    input wire logic bus_init_error_pin_n,
    input wire logic err_ip_valid_in,
    // Exception report
    output logic exc_valid,
    output logic [7:0] exc_vector,
    output logic exc_has_code,
    output logic [31:0] exc_code,
    output logic [31:0] exc_saved_ip,
    output logic exc_state_changed,
    output logic exc_abort,
    output logic shutdown
);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [4:0] align_need(input logic [3:0] kind, input logic osz32);
        unique case (op_kind_e'(kind))
            OP_WORD, OP_SELECTOR, OP_FAR32: align_need = 5'd2;
            OP_DWORD, OP_SINGLE, OP_PTR32, OP_FAR48, OP_TABLE_REG: align_need = 5'd4;
            OP_DOUBLE, OP_EXTENDED, OP_QWORD, OP_UNALIGNED_128: align_need = 5'd8;
            OP_DQWORD, OP_FULL_STATE: align_need = 5'd16;
            OP_SIZED_AREA: align_need = osz32 ? 5'd4 : 5'd2;
            default: align_need = 5'd1;
        endcase
    endfunction : align_need

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [5:0] ctrl_q;
    logic [5:0] fp_mask_q;
    logic fp_pend_q;
    logic [31:0] fp_ip_q;
    logic shutdown_q;
    logic err_ip_valid_q;
    logic mcip_q;
    logic [31:0] mc_addr_q;
    logic [31:0] saved_ip_q;
    logic ph_valid_q;
    logic ph_write_q;
    logic [7:0] ph_addr_q;

    wire num_err_en = ctrl_q[CTRL_NUM_ERR_BIT];
    wire align_mask_en = ctrl_q[CTRL_ALIGN_MASK_BIT];
    wire check_en = ctrl_q[CTRL_CHECK_EN_BIT];
    wire acf = ctrl_q[CTRL_ACF_BIT];
    wire fx_use_ac = ctrl_q[CTRL_FX_AC_BIT];
    wire pin_en = ctrl_q[CTRL_PIN_EN_BIT];

    // ---------------------------------------------------------------
    // Bus slave: zero wait states, always OKAY
    // ---------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    wire addr_ph = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid_q <= 1'b0;
            ph_write_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else begin
            ph_valid_q <= addr_ph;
            ph_write_q <= hwrite;
            ph_addr_q <= haddr;
        end
    end

    wire wr_ctrl = ph_valid_q && ph_write_q && ph_addr_q == OFS_CTRL;
    wire wr_mask = ph_valid_q && ph_write_q && ph_addr_q == OFS_FP_MASK;
    wire wr_status = ph_valid_q && ph_write_q && ph_addr_q == OFS_STATUS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RESET;
            fp_mask_q <= FP_MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= hwdata[5:0];
            end
            if (wr_mask) begin
                fp_mask_q <= hwdata[5:0];
            end
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (ph_valid_q && !ph_write_q) begin
            unique case (ph_addr_q)
                OFS_CTRL: hrdata = {26'h0, ctrl_q};
                OFS_FP_MASK: hrdata = {26'h0, fp_mask_q};
                OFS_STATUS: hrdata = {28'h0, mcip_q, err_ip_valid_q, shutdown_q, fp_pend_q};
                OFS_FP_IP: hrdata = fp_ip_q;
                OFS_MC_ADDR: hrdata = mc_addr_q;
                OFS_SAVED_IP: hrdata = saved_ip_q;
                default: hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Deferred fp error
    // ---------------------------------------------------------------
    wire fp_unmasked = fp_error_detect && |(fp_error_type & ~fp_mask_q) && num_err_en;
    wire fp_deliver = fp_pend_q && ins_valid && ins_class == INS_WAITING;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fp_pend_q <= 1'b0;
            fp_ip_q <= 32'h0000_0000;
        end else begin
            if (fp_unmasked) begin
                fp_pend_q <= 1'b1; // set wins over any clear
                fp_ip_q <= instr_ptr;
            end else if (fp_deliver || (wr_status && hwdata[ST_FP_PEND_BIT])) begin
                fp_pend_q <= 1'b0;
            end
        end
    end

    // ---------------------------------------------------------------
    // Alignment check
    // ---------------------------------------------------------------
    logic [4:0] need;
    logic misaligned;
    logic ac_active;
    logic is_gp;
    logic acc_fault_ac;
    logic acc_fault_gp;

    always_comb begin
        need = align_need(acc_kind, acc_opsize32);
        misaligned = |(acc_addr[4:0] & (need - 5'd1));
        ac_active = align_mask_en && acf && current_privilege_level == 2'd3;
        is_gp = 1'b0;
        if (acc_kind == OP_DQWORD) begin
            is_gp = misaligned;
        end else if (acc_kind == OP_FULL_STATE) begin
            is_gp = misaligned && !(ac_active && fx_use_ac);
        end
        acc_fault_gp = acc_valid && acc_data_seg && is_gp;
        acc_fault_ac = acc_valid && acc_data_seg && !acc_implicit_pl0 && ac_active
            && misaligned && !is_gp;
    end

    assign acc_go = acc_valid && !acc_fault_ac && !acc_fault_gp;

    // ---------------------------------------------------------------
    // Machine check
    // ---------------------------------------------------------------
    wire pin_hit = pin_en && (!check_error_pin_n || !bus_init_error_pin_n);
    wire mc_event = pin_hit && !mcip_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_ip_valid_q <= 1'b0;
            mcip_q <= 1'b0;
            mc_addr_q <= 32'h0000_0000;
            shutdown_q <= 1'b0;
        end else begin
            if (mc_event && check_en) begin
                mcip_q <= 1'b1;
                err_ip_valid_q <= err_ip_valid_in;
                mc_addr_q <= instr_ptr;
            end else if (wr_status && hwdata[ST_MCIP_BIT]) begin
                mcip_q <= 1'b0;
            end
            if (mc_event && !check_en) begin
                shutdown_q <= 1'b1;
            end
        end
    end
    assign shutdown = shutdown_q;

    // ---------------------------------------------------------------
    // Exception report, priority: machine, access faults, fp
    // ---------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exc_valid <= 1'b0;
            exc_vector <= 8'h00;
            exc_has_code <= 1'b0;
            exc_code <= 32'h0000_0000;
            exc_saved_ip <= 32'h0000_0000;
            exc_state_changed <= 1'b0;
            exc_abort <= 1'b0;
            saved_ip_q <= 32'h0000_0000;
        end else begin
            exc_valid <= 1'b0;
            exc_has_code <= 1'b0;
            exc_code <= 32'h0000_0000;
            exc_state_changed <= 1'b0;
            exc_abort <= 1'b0;
            if (mc_event && check_en) begin
                exc_valid <= 1'b1;
                exc_vector <= VEC_MACHINE;
                exc_abort <= 1'b1;
                exc_state_changed <= 1'b1;
                exc_saved_ip <= instr_ptr;
                saved_ip_q <= instr_ptr;
            end else if (acc_fault_gp) begin
                exc_valid <= 1'b1;
                exc_vector <= VEC_GPF;
                exc_has_code <= 1'b1;
                exc_saved_ip <= instr_ptr;
                saved_ip_q <= instr_ptr;
            end else if (acc_fault_ac) begin
                exc_valid <= 1'b1;
                exc_vector <= VEC_ALIGN;
                exc_has_code <= 1'b1; // code is zero
                exc_saved_ip <= instr_ptr;
                saved_ip_q <= instr_ptr;
            end else if (fp_deliver) begin
                exc_valid <= 1'b1;
                exc_vector <= VEC_FP_ERROR;
                exc_state_changed <= 1'b1;
                exc_saved_ip <= instr_ptr;
                saved_ip_q <= instr_ptr;
            end
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence fp_wait_seen_s;
        fp_pend_q && ins_valid && ins_class == INS_WAITING && !acc_fault_ac && !acc_fault_gp
            && !(mc_event && check_en);
    endsequence

    fp_deliver_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fp_wait_seen_s |=> exc_valid && exc_vector == VEC_FP_ERROR && !exc_has_code)
        else $error("fp error not raised on waiting instruction");
    fp_nowait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ins_valid && ins_class == INS_NOWAIT && !fp_unmasked && fp_pend_q |=> fp_pend_q)
        else $error("nowait instruction consumed pending fp error");
    fp_fullstate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ins_valid && ins_class == INS_FULL_STATE |=> !(exc_valid && exc_vector == VEC_FP_ERROR))
        else $error("full-state instruction delivered fp error");
    fp_enable_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !num_err_en && !fp_pend_q |=> !fp_pend_q)
        else $error("fp pending set with numeric error disabled");
    align_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        current_privilege_level != 2'd3 |-> !acc_fault_ac)
        else $error("alignment fault outside privilege 3");
    align_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_fault_ac |-> !acc_go ##1 (exc_valid && exc_code == 32'h0000_0000))
        else $error("misaligned access not blocked");
    align_implicit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_implicit_pl0 || !acc_data_seg |-> !acc_fault_ac)
        else $error("implicit or code access alignment faulted");
    mc_abort_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mc_event && check_en |=> exc_valid && exc_abort && exc_state_changed
            && exc_vector == VEC_MACHINE && !exc_has_code)
        else $error("machine abort report wrong");
    mc_shutdown_a: assert property (@(posedge hclk) disable iff (!hresetn)
        mc_event && !check_en |=> shutdown && !(exc_valid && exc_vector == VEC_MACHINE))
        else $error("disabled machine check did not shut down");

endmodule : exc_unit

`default_nettype wire

// file: exc_pkg.sv
// Package of constants for the exception decision unit
package exc_pkg;

    // ---------------------------------------------------------------
    // Vectors
    // ---------------------------------------------------------------
    localparam logic [7:0] VEC_FP_ERROR = 8'h10;
    localparam logic [7:0] VEC_ALIGN = 8'h11;
    localparam logic [7:0] VEC_MACHINE = 8'h12;
    localparam logic [7:0] VEC_GPF = 8'h0D;

    // ---------------------------------------------------------------
    // Register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FP_MASK = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FP_IP = 8'h0C;
    localparam logic [7:0] OFS_MC_ADDR = 8'h10;
    localparam logic [7:0] OFS_SAVED_IP = 8'h14;

    // ---------------------------------------------------------------
    // Control register field positions
    // ---------------------------------------------------------------
    localparam int CTRL_NUM_ERR_BIT = 0;
    localparam int CTRL_ALIGN_MASK_BIT = 1;
    localparam int CTRL_CHECK_EN_BIT = 2;
    localparam int CTRL_ACF_BIT = 3;
    localparam int CTRL_FX_AC_BIT = 4;
    localparam int CTRL_PIN_EN_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h20;
    localparam logic [5:0] FP_MASK_RESET = 6'h3F;

    // ---------------------------------------------------------------
    // Status register field positions
    // ---------------------------------------------------------------
    localparam int ST_FP_PEND_BIT = 0;
    localparam int ST_SHUTDOWN_BIT = 1;
    localparam int ST_ERR_IP_VALID_BIT = 2;
    localparam int ST_MCIP_BIT = 3;

    // ---------------------------------------------------------------
    // Operand kinds presented with each data access
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        OP_BYTE = 4'h0, OP_WORD = 4'h1, OP_DWORD = 4'h2, OP_SINGLE = 4'h3,
        OP_DOUBLE = 4'h4, OP_EXTENDED = 4'h5, OP_QWORD = 4'h6, OP_DQWORD = 4'h7,
        OP_SELECTOR = 4'h8, OP_FAR32 = 4'h9, OP_FAR48 = 4'hA, OP_PTR32 = 4'hB,
        OP_TABLE_REG = 4'hC, OP_SIZED_AREA = 4'hD, OP_FULL_STATE = 4'hE,
        OP_UNALIGNED_128 = 4'hF
    } op_kind_e;

    // Instruction classes seen by the deferred fp logic
    typedef enum logic [1:0] {
        INS_OTHER = 2'h0, INS_WAITING = 2'h1, INS_NOWAIT = 2'h2, INS_FULL_STATE = 2'h3
    } ins_class_e;

endpackage : exc_pkg

// file: pin_error_agent.sv
// External bus error agent that pulls the error pins of the exception unit
`timescale 1ns/1ns
`default_nettype none
module pin_error_agent (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fire,
    input wire logic pin_sel,
    input wire logic error_ip_valid_set,
    output logic check_error_pin_n,
    output logic bus_init_error_pin_n,
    output logic err_ip_valid_in
);
    // ---------------------------------------------------------------
    // Pin drive
    // ---------------------------------------------------------------
    logic [1:0] hold_q;
    logic sel_q;

    // Pin is held low two cycles, so a second capture would be a fault
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold_q <= 2'h0;
        end else if (fire) begin
            hold_q <= 2'h2;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 1'b0;
        end else if (fire) begin
            sel_q <= pin_sel;
        end
    end

    // Released pins return to their pulled-up level
    assign check_error_pin_n = !((hold_q != 2'h0) && !sel_q);
    assign bus_init_error_pin_n = !((hold_q != 2'h0) && sel_q);
    assign err_ip_valid_in = error_ip_valid_set;
endmodule : pin_error_agent
`default_nettype wire

// file: fp_align_machine_check_exceptions_bench.sv
// Self-checking bench for the exception decision unit
`timescale 1ns/1ns
`default_nettype none
module fp_align_machine_check_exceptions_bench;
    import exc_pkg::*;
    typedef struct packed {
        logic [3:0] kind;
        logic [7:0] addr;
        logic [2:0] sz_ds_pl0;
        logic [1:0] priv;
        logic go;
        logic [7:0] vec;
    } row_s;
    logic hclk, hresetn, hsel, hwrite, hready, fire, pin_sel, error_ip_valid_set;
    logic [7:0] haddr;
    logic [1:0] htrans, priv, ins_class;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, instr_ptr, acc_addr, rd;
    logic fp_error_detect, ins_valid, acc_valid, acc_opsize32, acc_data_seg, acc_implicit_pl0;
    logic [5:0] fp_error_type;
    logic [3:0] acc_kind;
    logic acc_go, check_error_pin_n, bus_init_error_pin_n, err_ip_valid_in, exc_valid;
    logic [7:0] exc_vector;
    logic exc_has_code, exc_state_changed, exc_abort, shutdown;
    logic [31:0] exc_code, exc_saved_ip;
    row_s rows [23];
    int fails, n_tests, cycles;

    exc_unit exc_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(), .current_privilege_level(priv),
        .instr_ptr(instr_ptr), .fp_error_detect(fp_error_detect), .fp_error_type(fp_error_type),
        .ins_valid(ins_valid), .ins_class(ins_class), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_kind(acc_kind), .acc_opsize32(acc_opsize32), .acc_data_seg(acc_data_seg),
        .acc_implicit_pl0(acc_implicit_pl0), .acc_go(acc_go),
        .check_error_pin_n(check_error_pin_n), .bus_init_error_pin_n(bus_init_error_pin_n),
        .err_ip_valid_in(err_ip_valid_in), .exc_valid(exc_valid), .exc_vector(exc_vector),
        .exc_has_code(exc_has_code), .exc_code(exc_code), .exc_saved_ip(exc_saved_ip),
        .exc_state_changed(exc_state_changed), .exc_abort(exc_abort), .shutdown(shutdown));
    pin_error_agent pin_error_agent_inst (.hclk(hclk), .hresetn(hresetn), .fire(fire),
        .pin_sel(pin_sel), .error_ip_valid_set(error_ip_valid_set), .check_error_pin_n(check_error_pin_n),
        .bus_init_error_pin_n(bus_init_error_pin_n), .err_ip_valid_in(err_ip_valid_in));

    always #25 hclk = ~hclk;

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
        end
    endtask : check

    // Callers enter just after a rising edge; the task leaves on one
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
        bus(a, 1'b0, 32'h0000_0000);
        check(rd, want);
    endtask : rdchk

    task automatic run_row(input row_s r);
        acc_valid <= 1'b1;
        acc_kind <= r.kind;
        acc_addr <= {24'h00_1000, r.addr};
        {acc_opsize32, acc_data_seg, acc_implicit_pl0} <= r.sz_ds_pl0;
        priv <= r.priv;
        @(negedge hclk);
        check(acc_go, r.go);
        @(posedge hclk);
        acc_valid <= 1'b0;
        @(negedge hclk);
        check(exc_valid, !r.go);
        if (!r.go) begin
            check(exc_vector, r.vec);
            check({exc_has_code, exc_state_changed}, 2'b10);
            check(exc_code, 32'h0000_0000);
            check(exc_saved_ip, instr_ptr);
        end
        @(posedge hclk);
    endtask : run_row

    task automatic ins(input logic [1:0] c, input logic want);
        ins_valid <= 1'b1;
        ins_class <= c;
        @(posedge hclk);
        ins_valid <= 1'b0;
        @(negedge hclk);
        check(exc_valid, want);
        if (want) begin
            check(exc_vector, VEC_FP_ERROR);
            check(exc_has_code, 1'b0);
            check(exc_saved_ip, instr_ptr);
        end
        @(posedge hclk);
    endtask : ins

    task automatic fp_hit(input logic [5:0] t);
        fp_error_detect <= 1'b1;
        fp_error_type <= t;
        @(posedge hclk);
        fp_error_detect <= 1'b0;
        @(posedge hclk);
    endtask : fp_hit

    task automatic mc_fire(input logic sel);
        pin_sel <= sel;
        fire <= 1'b1;
        @(posedge hclk);
        fire <= 1'b0;
        @(posedge hclk);
        @(negedge hclk);
    endtask : mc_fire

    task automatic rst();
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask : rst

    always @(posedge hclk) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict();
        end
    end

    // ---------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        {hresetn, hsel, hwrite, fire, pin_sel, error_ip_valid_set, fp_error_detect, ins_valid} = 8'h00;
        {acc_valid, acc_opsize32, acc_data_seg, acc_implicit_pl0} = 4'h0;
        {haddr, htrans, hsize, hwdata, priv, ins_class, fp_error_type, acc_kind} = 59'h0;
        instr_ptr = 32'h0000_4000;
        acc_addr = 32'h0000_0000;
        {fails, n_tests, cycles} = 96'h0;
        rows = '{'{OP_WORD, 8'h01, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_WORD, 8'h02, 3'h6, 2'h3, 1'b1, 8'h00}, '{OP_DWORD, 8'h02, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_SINGLE, 8'h04, 3'h6, 2'h3, 1'b1, 8'h00}, '{OP_DOUBLE, 8'h04, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_EXTENDED, 8'h08, 3'h6, 2'h3, 1'b1, 8'h00}, '{OP_QWORD, 8'h04, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_SELECTOR, 8'h01, 3'h6, 2'h3, 1'b0, VEC_ALIGN}, '{OP_FAR32, 8'h02, 3'h6, 2'h3, 1'b1, 8'h00},
            '{OP_FAR48, 8'h02, 3'h6, 2'h3, 1'b0, VEC_ALIGN}, '{OP_PTR32, 8'h02, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_TABLE_REG, 8'h02, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_SIZED_AREA, 8'h02, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_SIZED_AREA, 8'h02, 3'h2, 2'h3, 1'b1, 8'h00},
            '{OP_SIZED_AREA, 8'h01, 3'h2, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_UNALIGNED_128, 8'h08, 3'h6, 2'h3, 1'b1, 8'h00},
            '{OP_UNALIGNED_128, 8'h04, 3'h6, 2'h3, 1'b0, VEC_ALIGN},
            '{OP_DQWORD, 8'h08, 3'h6, 2'h3, 1'b0, VEC_GPF}, '{OP_FULL_STATE, 8'h08, 3'h6, 2'h3, 1'b0, VEC_GPF},
            '{OP_BYTE, 8'h01, 3'h6, 2'h3, 1'b1, 8'h00}, '{OP_WORD, 8'h01, 3'h4, 2'h3, 1'b1, 8'h00},
            '{OP_WORD, 8'h01, 3'h7, 2'h3, 1'b1, 8'h00}, '{OP_WORD, 8'h01, 3'h6, 2'h2, 1'b1, 8'h00}};
        rst();
        rdchk(OFS_CTRL, 32'h0000_0020);
        rdchk(OFS_FP_MASK, 32'h0000_003F);
        rdchk(8'h20, 32'h0000_0000);
        bus(OFS_CTRL, 1'b1, 32'h0000_002F);
        for (int i = 0; i < 23; i++) begin
            run_row(rows[i]);
        end
        // Flags bit clear, then full-state misalignment routed to the alignment fault
        bus(OFS_CTRL, 1'b1, 32'h0000_0027);
        run_row('{OP_WORD, 8'h01, 3'h6, 2'h3, 1'b1, 8'h00});
        bus(OFS_CTRL, 1'b1, 32'h0000_003F);
        run_row('{OP_FULL_STATE, 8'h08, 3'h6, 2'h3, 1'b0, VEC_ALIGN});
        bus(OFS_CTRL, 1'b1, 32'h0000_002E);
        bus(OFS_FP_MASK, 1'b1, 32'h0000_003E);
        fp_hit(6'h01);
        rdchk(OFS_STATUS, 32'h0000_0000);
        bus(OFS_CTRL, 1'b1, 32'h0000_002F);
        fp_hit(6'h02);
        rdchk(OFS_STATUS, 32'h0000_0000);
        instr_ptr <= 32'h0000_5550;
        fp_hit(6'h01);
        rdchk(OFS_STATUS, 32'h0000_0001);
        rdchk(OFS_FP_IP, 32'h0000_5550);
        ins(INS_NOWAIT, 1'b0);
        ins(INS_FULL_STATE, 1'b0);
        ins(INS_OTHER, 1'b0);
        instr_ptr <= 32'h0000_6660;
        ins(INS_WAITING, 1'b1);
        ins(INS_WAITING, 1'b0);
        error_ip_valid_set <= 1'b1;
        mc_fire(1'b0);
        check(exc_valid, 1'b1);
        check(exc_vector, VEC_MACHINE);
        check({exc_has_code, exc_abort, exc_state_changed}, 3'b011);
        @(posedge hclk);
        rdchk(OFS_STATUS, 32'h0000_000C);
        rdchk(OFS_MC_ADDR, 32'h0000_6660);
        bus(OFS_STATUS, 1'b1, 32'h0000_0008);
        bus(OFS_CTRL, 1'b1, 32'h0000_002B);
        mc_fire(1'b1);
        check(exc_valid, 1'b0);
        check(shutdown, 1'b1);
        @(posedge hclk);
        rst();
        check(shutdown, 1'b0);
        rdchk(OFS_CTRL, 32'h0000_0020);
        give_verdict();
    end
endmodule : fp_align_machine_check_exceptions_bench
`default_nettype wire
